// [tb/pin_model.sv]
// Outside circuit at the port pins and the slow master clock source
`timescale 1ns/1ps
module pin_model (
  input  wire logic        i_clk,
  input  wire logic [11:0] i_out,
  input  wire logic [11:0] i_oe,
  input  wire logic [11:0] i_ext,
  input  wire logic        i_slow_run,
  output logic      [11:0] o_pin,
  output logic             o_slow_clk
);
  logic [1:0] div;

  // ********************************
  // Pins and slow clock
  // ********************************
  // Driven lines read back the unit's level, the rest follow the outside
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
  // Slow clock stands low while stopped, so no sample slips in unseen
  initial div = 2'b00;
  always @(posedge i_clk)
    div <= i_slow_run ? div + 2'b01 : 2'b00;
  assign o_slow_clk = div[1];
endmodule : pin_model

// [tb/test_gpio_interrupt_port.sv]
// Self-checking bench for the port I/O unit
`timescale 1ns/1ps
module test_gpio_interrupt_port;
  import port_io_pkg::*;
  logic        i_clk, i_sys_rst, i_psel, i_penable, i_pwrite, i_carrier_detect;
  logic        o_pready, o_pslverr, o_irq, slow_clk, slow_run, err;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [11:0] pins, o_gpio_out, o_gpio_oe, ext;
  int          n_fail, compares;

  port_io_unit DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_paddr(i_paddr), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_gpio_in(pins), .o_gpio_out(o_gpio_out),
    .o_gpio_oe(o_gpio_oe), .i_carrier_detect(i_carrier_detect),
    .i_low_freq_master_clock(slow_clk), .o_irq(o_irq));
  pin_model ext_side (.i_clk(i_clk), .i_out(o_gpio_out), .i_oe(o_gpio_oe), .i_ext(ext),
    .i_slow_run(slow_run), .o_pin(pins), .o_slow_clk(slow_clk));

  // ********************************
  // Shared tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_pready !== 1'b1 && n < 20);
    chk({31'h0, o_pready}, 32'h1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    // Let the committed write show before the caller looks
    @(posedge i_clk);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic set_line(input int ln, input logic v);
    if (ln == CARRIER_BIT)
      i_carrier_detect <= v;
    else
      ext[ln] <= v;
  endtask : set_line

  task automatic tally_and_finish;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset;
    chk({7'h0, o_irq, o_gpio_oe, o_gpio_out}, 32'h0);
    rdchk(OFF_DIR, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask : t_reset

  task automatic t_dir_data;
    ext <= 12'h30F;
    i_carrier_detect <= 1'b1;
    apb(1'b1, OFF_DIR, 32'hFFFFFFFF);
    chk({20'h0, o_gpio_oe}, 32'hFFF);
    rdchk(OFF_DIR, 32'hFFF);
    apb(1'b1, OFF_DATA, 32'hFFFFFA5A);
    chk({20'h0, o_gpio_out}, 32'hA5A);
    rdchk(OFF_DATA, 32'h2A5A);
    apb(1'b1, OFF_DIR, 32'h0F0);
    rdchk(OFF_DATA, 32'h235F);
    i_carrier_detect <= 1'b0;
    rdchk(OFF_DATA, 32'h035F);
    apb(1'b1, OFF_DIR, 32'h0);
    chk({20'h0, o_gpio_oe}, 32'h0);
  endtask : t_dir_data

  task automatic t_masks;
    logic [7:0] a;
    for (int i = 0; i < 3; i++)
    begin
      a = OFF_INT_EN + 8'(4 * i);
      apb(1'b1, a, 32'hFFFFFFFF);
      rdchk(a, 32'h2DFF);
      apb(1'b1, a, 32'h0);
    end
    apb(1'b1, OFF_INT_STAT, 32'h3FFF);
  endtask : t_masks

  task automatic irq_case(input int ln, input logic edg, input logic hi, input logic slow);
    logic [31:0] b;
    int          n;
    b = 32'h1 << ln;
    n = 0;
    set_line(ln, ~hi);
    apb(1'b1, OFF_INT_EN, 32'h0);
    apb(1'b1, OFF_TRIG_EDGE, edg ? b : 32'h0);
    apb(1'b1, OFF_TRIG_HIGH, hi ? b : 32'h0);
    apb(1'b1, OFF_INT_STAT, 32'h3FFF);
    apb(1'b1, OFF_INT_EN, b);
    rdchk(OFF_INT_STAT, 32'h0);
    set_line(ln, hi);
    if (slow)
    begin
      repeat (30) @(posedge i_clk);
      chk({31'h0, o_irq}, 32'h0);
      slow_run <= 1'b1;
    end
    while (o_irq !== 1'b1 && n < 200)
    begin
      @(posedge i_clk);
      n++;
    end
    rdchk(OFF_INT_STAT, b);
    chk({31'h0, o_irq}, 32'h1);
    apb(1'b1, OFF_INT_STAT, b);
    repeat (20) @(posedge i_clk);
    // Edge stays cleared, a held level sets status again
    chk({31'h0, o_irq}, {31'h0, ~edg});
    rdchk(OFF_INT_STAT, edg ? 32'h0 : b);
    set_line(ln, ~hi);
    apb(1'b1, OFF_INT_EN, 32'h0);
    apb(1'b1, OFF_INT_STAT, 32'h3FFF);
    slow_run <= 1'b0;
  endtask : irq_case

  // ********************************
  // Clock, watchdog, main sequence
  // ********************************
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  initial
  begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    n_fail = 0;
    compares = 0;
    i_sys_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_carrier_detect = 1'b0;
    slow_run = 1'b0;
    ext = 12'h200;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_dir_data();
    t_masks();
    irq_case(3, 1'b1, 1'b1, 1'b0);
    irq_case(8, 1'b1, 1'b0, 1'b0);
    irq_case(0, 1'b0, 1'b0, 1'b0);
    irq_case(11, 1'b0, 1'b1, 1'b0);
    irq_case(10, 1'b0, 1'b1, 1'b1);
    irq_case(CARRIER_BIT, 1'b0, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule : test_gpio_interrupt_port

// [verilog/port_io_pkg.sv]
// Constants, register map and address decode functions shared by the port I/O unit
package port_io_pkg;

  // ****************************************************************
  // Line layout
  // ****************************************************************
  localparam int          NUM_GPIO      = 12;
  localparam int          NUM_LINES     = 14;
  localparam int          CARRIER_BIT   = 13;
  localparam int          RESERVED_LINE = 9;
  localparam int          ADDR_W        = 8;

  // Lines that may raise a request: 13, 11, 10, 8..0
  localparam logic [13:0] INT_CAPABLE   = 14'h2DFF;
  // Lines sampled on the slow master clock: 13, 10, 9
  localparam logic [13:0] SLOW_SAMPLED  = 14'h2600;

  // ****************************************************************
  // Register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0]  OFF_DIR       = 8'h00;
  localparam logic [7:0]  OFF_DATA      = 8'h04;
  localparam logic [7:0]  OFF_INT_STAT  = 8'h08;
  localparam logic [7:0]  OFF_INT_EN    = 8'h0C;
  localparam logic [7:0]  OFF_TRIG_EDGE = 8'h10;
  localparam logic [7:0]  OFF_TRIG_HIGH = 8'h14;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [11:0] RST_DIR       = 12'h000;
  localparam logic [11:0] RST_DOUT      = 12'h000;
  localparam logic [13:0] RST_LINES     = 14'h0000;
  localparam logic [31:0] RST_WORD      = 32'h00000000;

  function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] off);
    is_reg = (addr == off);
  endfunction : is_reg

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = is_reg(addr, OFF_DIR) | is_reg(addr, OFF_DATA)
                | is_reg(addr, OFF_INT_STAT) | is_reg(addr, OFF_INT_EN)
                | is_reg(addr, OFF_TRIG_EDGE) | is_reg(addr, OFF_TRIG_HIGH);
  endfunction : addr_mapped

endpackage : port_io_pkg

// [verilog/port_io_unit.sv]
// Port I/O unit: twelve port lines, carrier-detect, triggers, APB registers
//
// Summary of operation
// - Twelve port lines, each input or output
// - Eleven lines plus carrier-detect raise requests
// - Trigger per line: edge, low or high
// - Lines 9,10,carrier on slow clock; rest fast
// - Carrier-detect read at data bit 13
// - Carrier-detect is input only
// - Reset makes every line an input
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module port_io_unit (
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic [port_io_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [31:0]                   i_pwdata,
  output logic      [31:0]                   o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  input  wire logic [port_io_pkg::NUM_GPIO-1:0] i_gpio_in,
  output logic      [port_io_pkg::NUM_GPIO-1:0] o_gpio_out,
  output logic      [port_io_pkg::NUM_GPIO-1:0] o_gpio_oe,
  input  wire logic                          i_carrier_detect,
  input  wire logic                          i_low_freq_master_clock,
  output logic                               o_irq
);
  import port_io_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [11:0] dir;
    logic [11:0] dout;
    logic [13:0] ist;
    logic [13:0] ien;
    logic [13:0] trig_edge;
    logic [13:0] trig_high;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
  } unit_state_s;

  localparam unit_state_s RESET_STATE = '{
    dir:       RST_DIR,
    dout:      RST_DOUT,
    ist:       RST_LINES,
    ien:       RST_LINES,
    trig_edge: RST_LINES,
    trig_high: RST_LINES,
    pready:    1'b0,
    pslverr:   1'b0,
    prdata:    RST_WORD,
    irq:       1'b0
  };

  unit_state_s st;
  unit_state_s next_st;
  logic        slow_tick_q;
  logic [13:0] pin_level;

  trig_if trig ();

  // ****************************************************************
  // Submodules
  // ****************************************************************
  slow_tick u_slow_tick (
    .i_clk                   (i_clk),
    .i_sys_rst               (i_sys_rst),
    .i_low_freq_master_clock (i_low_freq_master_clock),
    .o_tick                  (slow_tick_q)
  );

  trig_detect u_trig_detect (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .trig      (trig)
  );

  // Output lines read back their driven value, inputs their pin
  assign pin_level = {i_carrier_detect, 1'b0,
                      (st.dir & st.dout) | (~st.dir & i_gpio_in)};
  assign trig.level     = pin_level;
  assign trig.sample_en = (SLOW_SAMPLED & {14{slow_tick_q}}) | ~SLOW_SAMPLED;
  assign trig.edge_mode = st.trig_edge;
  assign trig.high_pol  = st.trig_high;

  // ****************************************************************
  // Register access and interrupt status
  // ****************************************************************
  always_comb
  begin
    logic        commit;
    logic [13:0] clear;
    logic [13:0] set;
    logic [31:0] rdata;
    next_st = st;
    commit  = i_psel & i_penable & st.pready & i_pwrite;
    clear   = 14'h0000;
    set     = 14'h0000;
    rdata   = RST_WORD;

    // One wait state: ready is raised in the second access cycle
    next_st.pready  = i_psel & i_penable & ~st.pready;
    next_st.pslverr = i_psel & i_penable & ~st.pready & ~addr_mapped(i_paddr);

    if (is_reg(i_paddr, OFF_DIR))
      rdata = {20'h00000, st.dir};
    else if (is_reg(i_paddr, OFF_DATA))
      rdata = {18'h00000, pin_level};
    else if (is_reg(i_paddr, OFF_INT_STAT))
      rdata = {18'h00000, st.ist};
    else if (is_reg(i_paddr, OFF_INT_EN))
      rdata = {18'h00000, st.ien};
    else if (is_reg(i_paddr, OFF_TRIG_EDGE))
      rdata = {18'h00000, st.trig_edge};
    else if (is_reg(i_paddr, OFF_TRIG_HIGH))
      rdata = {18'h00000, st.trig_high};
    next_st.prdata = next_st.pready ? rdata : st.prdata;

    if (commit)
    begin
      if (is_reg(i_paddr, OFF_DIR))
        next_st.dir = i_pwdata[11:0];
      if (is_reg(i_paddr, OFF_DATA))
        next_st.dout = i_pwdata[11:0];
      if (is_reg(i_paddr, OFF_INT_STAT))
        clear = i_pwdata[13:0];
      // Bit 13 has no drive bits anywhere; bit 9 and 12 never enable
      if (is_reg(i_paddr, OFF_INT_EN))
        next_st.ien = i_pwdata[13:0] & INT_CAPABLE;
      if (is_reg(i_paddr, OFF_TRIG_EDGE))
        next_st.trig_edge = i_pwdata[13:0] & INT_CAPABLE;
      if (is_reg(i_paddr, OFF_TRIG_HIGH))
        next_st.trig_high = i_pwdata[13:0] & INT_CAPABLE;
    end

    // Set wins over a clear in the same cycle, so no event is lost
    set         = trig.hit & st.ien & INT_CAPABLE;
    next_st.ist = (st.ist & ~clear) | set;
    next_st.irq = |next_st.ist;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      st <= RESET_STATE;
    else
      st <= next_st;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_prdata   = st.prdata;
  assign o_pready   = st.pready;
  assign o_pslverr  = st.pslverr;
  // Only twelve drive bits exist; carrier-detect has none
  assign o_gpio_oe  = st.dir;
  assign o_gpio_out = st.dout;
  assign o_irq      = st.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_reset_inputs;
    @(posedge i_clk)
    i_sys_rst |=> (o_gpio_oe == 12'h000);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("line driven after reset");

  property p_dir_write;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_psel && i_penable && o_pready && i_pwrite && i_paddr == OFF_DIR)
      |=> (o_gpio_oe == $past(i_pwdata[11:0]));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not taken");

  property p_carrier_read;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_psel && i_penable && !o_pready && !i_pwrite && i_paddr == OFF_DATA)
      |=> (o_pready && o_prdata[13] == $past(i_carrier_detect) && o_prdata[12] == 1'b0);
  endproperty
  a_carrier_read: assert property (p_carrier_read) else $error("carrier bit wrong");

  property p_reserved_quiet;
    @(posedge i_clk) disable iff (i_sys_rst)
    !st.ist[RESERVED_LINE] && !st.ist[12];
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved line flagged");

  property p_set_from_hit;
    @(posedge i_clk) disable iff (i_sys_rst)
    (trig.hit[0] && st.ien[0]) |=> (st.ist[0] && o_irq);
  endproperty
  a_set_from_hit: assert property (p_set_from_hit) else $error("status not latched");

  property p_sticky;
    @(posedge i_clk) disable iff (i_sys_rst)
    (st.ist[3] && !(i_psel && i_penable && o_pready && i_pwrite
                     && i_paddr == OFF_INT_STAT && i_pwdata[3])) |=> st.ist[3];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost");

  property p_irq_level;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_irq == (st.ist != 14'h0000);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("request mismatch");

  property p_slow_gate;
    @(posedge i_clk) disable iff (i_sys_rst)
    !slow_tick_q |=> !trig.hit[10] && !trig.hit[CARRIER_BIT];
  endproperty
  a_slow_gate: assert property (p_slow_gate) else $error("slow line off tick");

  property p_ready_one;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_pready |=> !o_pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready stuck");

  // ****************************************************************
  // Register and trigger checks
  // ****************************************************************
  property p_data_write;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_psel && i_penable && o_pready && i_pwrite && i_paddr == OFF_DATA)
      |=> (o_gpio_out == $past(i_pwdata[11:0]));
  endproperty
  a_data_write: assert property (p_data_write) else $error("output latch not taken");

  property p_unmapped_ignored;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_psel && i_penable && o_pready && i_pwrite && !addr_mapped(i_paddr))
      |=> ($stable(o_gpio_oe) && $stable(o_gpio_out));
  endproperty
  a_unmapped_ignored: assert property (p_unmapped_ignored) else $error("stray write");

  property p_ien_mask;
    @(posedge i_clk) disable iff (i_sys_rst)
    (st.ien & ~INT_CAPABLE) == 14'h0000;
  endproperty
  a_ien_mask: assert property (p_ien_mask) else $error("enable on dead line");

  property p_reserved_off;
    @(posedge i_clk) disable iff (i_sys_rst)
    !st.ien[RESERVED_LINE] && !st.ien[12];
  endproperty
  a_reserved_off: assert property (p_reserved_off) else $error("reserved enabled");

  property p_trig_mask;
    @(posedge i_clk) disable iff (i_sys_rst)
    ((st.trig_edge | st.trig_high) & ~INT_CAPABLE) == 14'h0000;
  endproperty
  a_trig_mask: assert property (p_trig_mask) else $error("trigger on dead line");

  property p_low_level_hit;
    @(posedge i_clk) disable iff (i_sys_rst)
    (!st.trig_edge[0] && !st.trig_high[0] && !pin_level[0]) |=> trig.hit[0];
  endproperty
  a_low_level_hit: assert property (p_low_level_hit) else $error("low level missed");

  property p_high_level_hit;
    @(posedge i_clk) disable iff (i_sys_rst)
    (!st.trig_edge[11] && st.trig_high[11] && pin_level[11]) |=> trig.hit[11];
  endproperty
  a_high_level_hit: assert property (p_high_level_hit) else $error("high level missed");

  property p_fast_sample;
    @(posedge i_clk) disable iff (i_sys_rst)
    (trig.sample_en[8:0] == 9'h1FF) && trig.sample_en[11];
  endproperty
  a_fast_sample: assert property (p_fast_sample) else $error("fast line gated");

  property p_upper_zero;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_pready |-> (o_prdata[31:14] == 18'h00000);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

  // A clear loses against a new event on the same line
  property p_clear_works;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_psel && i_penable && o_pready && i_pwrite && i_paddr == OFF_INT_STAT
     && i_pwdata[3] && !(trig.hit[3] && st.ien[3])) |=> !st.ist[3];
  endproperty
  a_clear_works: assert property (p_clear_works) else $error("status not cleared");

  property p_disabled_no_set;
    @(posedge i_clk) disable iff (i_sys_rst)
    (!st.ist[0] && !st.ien[0]) |=> !st.ist[0];
  endproperty
  a_disabled_no_set: assert property (p_disabled_no_set) else $error("masked line set");

  property p_reset_quiet;
    @(posedge i_clk)
    i_sys_rst |=> (!o_irq && st.ist == 14'h0000);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("request after reset");

endmodule : port_io_unit

// [verilog/slow_tick.sv]
// Sample pulse from the rising edge of the low-frequency master clock
`timescale 1ns/1ps
module slow_tick (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_low_freq_master_clock,
  output logic      o_tick
);
  typedef struct packed {
    logic slow_q;
    logic tick;
  } tick_state_s;

  tick_state_s st;
  tick_state_s next_st;

  always_comb
  begin
    next_st        = st;
    next_st.slow_q = i_low_freq_master_clock;
    next_st.tick   = i_low_freq_master_clock & ~st.slow_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_tick = st.tick;

  property p_tick_on_rise;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_low_freq_master_clock && !st.slow_q) |=> o_tick;
  endproperty
  a_tick_on_rise: assert property (p_tick_on_rise) else $error("slow tick missed");
endmodule : slow_tick

// [verilog/trig_detect.sv]
// Per-line trigger detector: edge or level, chosen polarity
`timescale 1ns/1ps
module trig_detect (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  trig_if.det       trig
);
  import port_io_pkg::*;

  typedef struct packed {
    logic [13:0] prev;
    logic [13:0] hit;
  } det_state_s;

  det_state_s st;
  det_state_s next_st;

  always_comb
  begin
    logic [13:0] rise;
    logic [13:0] fall;
    logic [13:0] cond;
    rise    = trig.level & ~st.prev;
    fall    = ~trig.level & st.prev;
    next_st = st;
    // High polarity: rising edge or high level; low: falling edge or low level
    cond    = (trig.edge_mode & ((trig.high_pol & rise) | (~trig.high_pol & fall)))
            | (~trig.edge_mode & ((trig.high_pol & trig.level)
                                 | (~trig.high_pol & ~trig.level)));
    // Lines only look at their input on their own sample clock
    next_st.hit  = cond & trig.sample_en;
    next_st.prev = (trig.level & trig.sample_en) | (st.prev & ~trig.sample_en);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign trig.hit = st.hit;

  property p_no_hit_unsampled;
    @(posedge i_clk) disable iff (i_sys_rst)
    ##1 (trig.hit & ~$past(trig.sample_en)) == 14'h0000;
  endproperty
  a_no_hit_unsampled: assert property (p_no_hit_unsampled) else $error("hit off tick");

  property p_rise_hit;
    @(posedge i_clk) disable iff (i_sys_rst)
    (trig.sample_en[3] && trig.edge_mode[3] && trig.high_pol[3]
     && trig.level[3] && !st.prev[3]) |=> trig.hit[3];
  endproperty
  a_rise_hit: assert property (p_rise_hit) else $error("rising edge not seen");
endmodule : trig_detect

// [verilog/trig_if.sv]
// Carrier between the unit and its trigger detector
`timescale 1ns/1ps
interface trig_if;
  logic [13:0] level;
  logic [13:0] sample_en;
  logic [13:0] edge_mode;
  logic [13:0] high_pol;
  logic [13:0] hit;

  modport ctrl (output level, output sample_en, output edge_mode, output high_pol,
                input hit);
  modport det  (input level, input sample_en, input edge_mode, input high_pol,
                output hit);
endinterface : trig_if
